// File: inc/csio_pkg.sv
package csio_pkg;
   // ----------------------------------------------------------------
   // clocking
   // ----------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ = 200_000_000;
   localparam int unsigned MCLK_HZ = 8_000_000;
   localparam int unsigned LOGIC_DIV = 32;
   localparam int unsigned LOGIC_HZ = MCLK_HZ / LOGIC_DIV;
   localparam int unsigned MCLK_DIV = SYS_CLK_HZ / MCLK_HZ;
   // oscillator restart time after wake, least time, rounded up
   localparam int unsigned OSC_START_NS = 1000;
   localparam int unsigned OSC_START_CYC = (OSC_START_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;

   // ----------------------------------------------------------------
   // timers
   // ----------------------------------------------------------------
   localparam int unsigned NUM_TIMERS = 4;
   localparam int unsigned TIMER_MIN_US = 32;
   localparam int unsigned TIMER_MAX_MS = 1960;
   localparam int unsigned TIMER_MIN_TICKS = TIMER_MIN_US * LOGIC_HZ / 1_000_000;
   localparam int unsigned TIMER_MAX_TICKS = TIMER_MAX_MS * (LOGIC_HZ / 1000);
   localparam int unsigned TCNT_W = 19;
   localparam int unsigned STEP_W = 7;

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   localparam int unsigned NUM_DIN = 2;
   localparam int unsigned NUM_IO = 5;
   localparam int unsigned NUM_MC = 8;
   localparam int unsigned MSEL_W = 3;

   // ----------------------------------------------------------------
   // register map, byte addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] REG_CONFIG = 6'h00;
   localparam logic [5:0] REG_SIGNATURE = 6'h04;
   localparam logic [5:0] REG_MACRO = 6'h08;
   localparam logic [5:0] REG_PINSEL = 6'h0c;
   localparam logic [5:0] REG_TCTRL = 6'h10;
   localparam logic [5:0] REG_TSTAT = 6'h14;
   localparam logic [5:0] REG_TSTEP0 = 6'h18;
   localparam logic [5:0] REG_INPUTS = 6'h28;

   // field positions
   localparam int unsigned CFG_SLEEP_EN = 0;
   localparam int unsigned CFG_SLEEP_SRC = 1;
   localparam int unsigned CFG_IO_DIR = 2;
   localparam int unsigned MAC_SLEEP_REQ = 8;
   localparam int unsigned TST_DONE = 4;
   localparam int unsigned INP_IO = 2;
   localparam int unsigned INP_WAKE = 7;
   localparam int unsigned INP_SLEEP = 8;

   // reset values
   localparam logic [31:0] SIGNATURE_RST = 32'h0000_0000;
   localparam logic [NUM_IO-1:0] IO_DIR_RST = 5'h1f;

   typedef enum logic [1:0] {ST_POR, ST_RUN, ST_SLEEP, ST_WAKE} csio_state_type;
endpackage

// File: src/csio_top.sv
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

module csio_top
   import csio_pkg::*;
#(
   parameter int unsigned MDIV = MCLK_DIV,
   parameter int unsigned LDIV = LOGIC_DIV,
   parameter int unsigned OSC_CYC = OSC_START_CYC
) (
   input wire logic clk_sys, // system clock, 200 MHz
   input wire logic resetn, // synchronous reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic [5:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes of a write
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // low for the cycle that completes
   input wire logic wake_sleep_pin, // wake/sleep level pin
   input wire logic [NUM_DIN-1:0] din_pin, // dedicated digital inputs
   input wire logic [NUM_IO-1:0] io_in, // dual-role pin levels
   output logic [NUM_IO-1:0] io_out, // dual-role pin drive value, always low
   output logic [NUM_IO-1:0] io_oe_n, // low while pulling the pin low
   output logic sleep_active, // high while powered down
   output logic mclk_tick, // one-cycle pulse at 8 MHz rate
   output logic logic_tick, // one-cycle pulse at 250 kHz rate
   output logic [NUM_TIMERS-1:0] timer_done // sticky timer expiry flags
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // divider counters are five bits wide, the wake counter eight
   if (MDIV < 2 || MDIV > 32) begin
      $error("MDIV out of range");
   end
   if (LDIV < 2 || LDIV > 32) begin
      $error("LDIV out of range");
   end
   if (OSC_CYC < 1 || OSC_CYC > 255) begin
      $error("OSC_CYC out of range");
   end

   localparam logic [4:0] MDIV_LAST = 5'(MDIV - 1);
   localparam logic [4:0] LDIV_LAST = 5'(LDIV - 1);
   localparam logic [7:0] OSC_LAST = 8'(OSC_CYC - 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      csio_state_type state;
      logic [4:0] mdiv;
      logic [4:0] ldiv;
      logic [7:0] wcnt;
      logic sleep_en;
      logic sleep_src;
      logic [NUM_IO-1:0] io_dir;
      logic [31:0] sig;
      logic [NUM_MC-1:0] mc_out;
      logic sleep_req;
      logic [NUM_IO-1:0][MSEL_W-1:0] pinsel;
      logic [NUM_TIMERS-1:0][STEP_W-1:0] step;
      logic [NUM_TIMERS-1:0][TCNT_W-1:0] tcnt;
      logic [NUM_TIMERS-1:0] trun;
      logic [NUM_TIMERS-1:0] tdone;
      logic [NUM_DIN-1:0] din_s1;
      logic [NUM_DIN-1:0] din_s2;
      logic [NUM_IO-1:0] io_s1;
      logic [NUM_IO-1:0] io_s2;
      logic wk_s1;
      logic wk_s2;
      logic [NUM_IO-1:0] oe_n;
      logic [NUM_IO-1:0] lvl;
      logic sleep;
      logic mtick;
      logic ltick;
      logic waitreq;
      logic [31:0] rdata;
   } csio_regs_type;

   csio_regs_type st_ff;
   csio_regs_type nxt_st;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // merge written byte lanes into an old word
   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction

   // step code to logic ticks: (mant+1)*min << 2*exp, clamped to the top
   function automatic logic [TCNT_W-1:0] timer_ticks(input logic [STEP_W-1:0] s);
      logic [31:0] t;
      t = 32'((32'(s[3:0]) + 32'd1) * TIMER_MIN_TICKS) << (2 * s[6:4]);
      if (t > TIMER_MAX_TICKS) begin
         t = TIMER_MAX_TICKS;
      end
      return TCNT_W'(t);
   endfunction

   // power-on values of everything that is lost in sleep
   // bus, configuration and the wake synchroniser are kept on purpose
   function automatic csio_regs_type clear_volatile(input csio_regs_type s);
      csio_regs_type r;
      r = s;
      r.mdiv = '0;
      r.ldiv = '0;
      r.mc_out = '0;
      r.sleep_req = 1'b1;
      r.tcnt = '0;
      r.trun = '0;
      r.tdone = '0;
      r.din_s1 = '0;
      r.din_s2 = '0;
      r.io_s1 = '0;
      r.io_s2 = '0;
      r.mtick = 1'b0;
      r.ltick = 1'b0;
      return r;
   endfunction

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      logic sleep_cond;
      logic req;
      logic take;
      logic mt;
      logic lt;
      logic [NUM_TIMERS-1:0] tstart;
      logic [NUM_TIMERS-1:0] tclr;
      logic [NUM_TIMERS-1:0] texp;
      logic [31:0] rd;
      sleep_cond = 1'b0;
      req = 1'b0;
      take = 1'b0;
      mt = 1'b0;
      lt = 1'b0;
      tstart = '0;
      tclr = '0;
      texp = '0;
      rd = '0;
      nxt_st = st_ff;

      // sleep condition; request is active low, pin high always wins
      sleep_cond = st_ff.sleep_en && !wake_sleep_pin
                   && (!st_ff.sleep_src || !st_ff.sleep_req);

      // bus handshake: one wait cycle, completion when waitrequest is low
      // a request seen while ce is low is answered once ce returns
      req = avs_read || avs_write;
      take = req && !st_ff.waitreq;
      nxt_st.waitreq = !(req && st_ff.waitreq);

      // register writes land on the completing edge only
      if (take && avs_write) begin
         case (avs_address)
            REG_CONFIG: begin
               // configuration store, loaded by the programming host
               nxt_st.sleep_en = avs_byteenable[0] ? avs_writedata[CFG_SLEEP_EN]
                                                  : st_ff.sleep_en;
               nxt_st.sleep_src = avs_byteenable[0] ? avs_writedata[CFG_SLEEP_SRC]
                                                   : st_ff.sleep_src;
               nxt_st.io_dir = avs_byteenable[0] ? avs_writedata[CFG_IO_DIR +: NUM_IO]
                                                : st_ff.io_dir;
            end
            REG_SIGNATURE: begin
               nxt_st.sig = be_merge(st_ff.sig, avs_writedata, avs_byteenable);
            end
            REG_MACRO: begin
               {nxt_st.sleep_req, nxt_st.mc_out} =
                  9'(be_merge({23'h0, st_ff.sleep_req, st_ff.mc_out}, avs_writedata,
                              avs_byteenable));
            end
            REG_PINSEL: begin
               nxt_st.pinsel = 15'(be_merge({17'h0, st_ff.pinsel}, avs_writedata,
                                            avs_byteenable));
            end
            REG_TCTRL: begin
               tstart = avs_byteenable[0] ? avs_writedata[NUM_TIMERS-1:0] : '0;
            end
            REG_TSTAT: begin
               tclr = avs_byteenable[0] ? avs_writedata[TST_DONE +: NUM_TIMERS] : '0;
            end
            REG_TSTEP0, REG_TSTEP0 + 6'h04, REG_TSTEP0 + 6'h08, REG_TSTEP0 + 6'h0c: begin
               if (avs_byteenable[0]) begin
                  nxt_st.step[2'(6'(avs_address - REG_TSTEP0) >> 2)] = avs_writedata[STEP_W-1:0];
               end
            end
            default: begin
               // unmapped and read-only words ignore writes
            end
         endcase
      end

      // read data prepared with the edge that drops waitrequest
      case (avs_address)
         REG_CONFIG: rd = 32'({st_ff.io_dir, st_ff.sleep_src, st_ff.sleep_en});
         REG_SIGNATURE: rd = st_ff.sig;
         REG_MACRO: rd = 32'({st_ff.sleep_req, st_ff.mc_out});
         REG_PINSEL: rd = 32'(st_ff.pinsel);
         REG_TSTAT: rd = 32'({st_ff.tdone, st_ff.trun});
         REG_TSTEP0: rd = 32'(st_ff.step[0]);
         REG_TSTEP0 + 6'h04: rd = 32'(st_ff.step[1]);
         REG_TSTEP0 + 6'h08: rd = 32'(st_ff.step[2]);
         REG_TSTEP0 + 6'h0c: rd = 32'(st_ff.step[3]);
         REG_INPUTS: rd = 32'({st_ff.sleep, st_ff.wk_s2, st_ff.io_s2, st_ff.din_s2});
         default: rd = 32'h0000_0000;
      endcase
      // readdata then stands until the next read, so a slow master still sees it
      if (avs_read && st_ff.waitreq) begin
         nxt_st.rdata = rd;
      end

      // clock dividers: master tick from the system clock, logic tick from that
      if (st_ff.state == ST_RUN) begin
         mt = (st_ff.mdiv == MDIV_LAST);
         nxt_st.mdiv = mt ? 5'h00 : 5'(st_ff.mdiv + 5'h01);
         if (mt) begin
            lt = (st_ff.ldiv == LDIV_LAST);
            nxt_st.ldiv = lt ? 5'h00 : 5'(st_ff.ldiv + 5'h01);
         end
      end
      nxt_st.mtick = mt; // also paces monitor sampling outside
      nxt_st.ltick = lt; // common tick for macrocell state

      // input registers: two stages, each on the master tick
      // the first stage is read only by the second, never by the logic
      if (mt) begin
         nxt_st.din_s1 = din_pin;
         nxt_st.din_s2 = st_ff.din_s1;
         nxt_st.io_s1 = io_in & st_ff.io_dir;
         nxt_st.io_s2 = st_ff.io_s1;
      end
      // wake pin keeps its own path since it is watched while asleep
      nxt_st.wk_s1 = wake_sleep_pin;
      nxt_st.wk_s2 = st_ff.wk_s1;

      // timers count logic ticks; start restarts, set beats clear
      for (int i = 0; i < NUM_TIMERS; i++) begin
         // a start on the expiry edge wins: the timer reloads, no done flag
         if (tstart[i]) begin
            nxt_st.tcnt[i] = timer_ticks(st_ff.step[i]);
            nxt_st.trun[i] = 1'b1;
         end else if (st_ff.trun[i] && lt) begin
            nxt_st.tcnt[i] = TCNT_W'(st_ff.tcnt[i] - 1'b1);
            if (st_ff.tcnt[i] == TCNT_W'(1)) begin
               nxt_st.trun[i] = 1'b0;
               texp[i] = 1'b1;
            end
         end
      end
      nxt_st.tdone = (st_ff.tdone & ~tclr) | texp;

      // open-drain drivers: pull low only in output mode while awake
      for (int p = 0; p < NUM_IO; p++) begin
         nxt_st.oe_n[p] = st_ff.io_dir[p]
                          || st_ff.mc_out[st_ff.pinsel[p]]
                          || st_ff.state != ST_RUN;
      end
      nxt_st.lvl = '0;

      // power sequencing
      case (st_ff.state)
         ST_POR: begin
            // decide before any logic runs
            nxt_st.state = sleep_cond ? ST_SLEEP : ST_RUN;
            nxt_st = clear_volatile(nxt_st);
         end
         ST_RUN: begin
            if (sleep_cond) begin
               // logic state is lost from the entry edge on, so pins are released
               // and the ticks stop in the same cycle that sleep_active rises
               nxt_st.state = ST_SLEEP;
               nxt_st = clear_volatile(nxt_st);
               nxt_st.oe_n = '1;
            end
         end
         ST_SLEEP: begin
            // oscillator stopped; only the wake pin is watched
            nxt_st = clear_volatile(nxt_st);
            nxt_st.oe_n = '1;
            nxt_st.wcnt = 8'h00;
            if (wake_sleep_pin) begin
               nxt_st.state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            // internal reset held until the oscillator has restarted
            // a pin that drops again meanwhile sends POR straight back to sleep when sleep_src is 0
            nxt_st = clear_volatile(nxt_st);
            nxt_st.oe_n = '1;
            nxt_st.wcnt = 8'(st_ff.wcnt + 8'h01);
            if (st_ff.wcnt == OSC_LAST) begin
               nxt_st.state = ST_POR;
            end
         end
         default: begin
            nxt_st.state = ST_POR;
         end
      endcase
      nxt_st.sleep = (nxt_st.state == ST_SLEEP);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // configuration survives sleep; only resetn returns it to defaults
   // ce low freezes a bus answer in flight as well; the master just waits longer
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '0;
         st_ff.state <= ST_POR;
         st_ff.io_dir <= IO_DIR_RST;
         st_ff.sig <= SIGNATURE_RST;
         st_ff.sleep_req <= 1'b1;
         st_ff.oe_n <= '1;
         st_ff.waitreq <= 1'b1;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign avs_readdata = st_ff.rdata;
   assign avs_waitrequest = st_ff.waitreq;
   // open-drain value: the pin is only ever pulled low, never driven high
   assign io_out = st_ff.lvl;
   assign io_oe_n = st_ff.oe_n;
   assign sleep_active = st_ff.sleep;
   assign mclk_tick = st_ff.mtick;
   assign logic_tick = st_ff.ltick;
   assign timer_done = st_ff.tdone;

endmodule
`default_nettype wire

// File: tb/csio_properties.sv
`timescale 1ns/1ps
`default_nettype none

module csio_properties
   import csio_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic resetn, // sync reset, active low
   input wire logic ce, // clock enable
   input wire logic [5:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   input wire logic [31:0] avs_readdata, // read data
   input wire logic avs_waitrequest, // bus stall
   input wire logic wake_sleep_pin, // wake level
   input wire logic [NUM_DIN-1:0] din_pin, // dedicated inputs
   input wire logic [NUM_IO-1:0] io_in, // dual-role levels
   input wire logic [NUM_IO-1:0] io_out, // drive value
   input wire logic [NUM_IO-1:0] io_oe_n, // low pulls pin low
   input wire logic sleep_active, // powered down
   input wire logic mclk_tick, // master tick
   input wire logic logic_tick, // logic tick
   input wire logic [NUM_TIMERS-1:0] timer_done // expiry flags
);
   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   sequence s_taken;
      (avs_read || avs_write) && avs_waitrequest && ce;
   endsequence
   // frozen clock enable may stretch the answer cycle
   sequence s_answer;
      !avs_waitrequest ##1 (avs_waitrequest || !ce);
   endsequence
   chk_req_answer: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_taken |=> s_answer) else $error("bus request not answered in one cycle");
   chk_wait_cause: assert property (@(posedge clk_sys) disable iff (!resetn)
      !avs_waitrequest |-> $past(avs_read) || $past(avs_write)) else $error("answer without request");
   chk_read_stable: assert property (@(posedge clk_sys) disable iff (!resetn)
      !avs_read |=> $stable(avs_readdata)) else $error("read data changed without a read");

   // ----------------------------------------------------------------
   // pins and power-down
   // ----------------------------------------------------------------
   chk_io_out_low: assert property (@(posedge clk_sys) disable iff (!resetn)
      io_out == 5'h00) else $error("open-drain value not low");
   chk_sleep_hiz: assert property (@(posedge clk_sys) disable iff (!resetn)
      sleep_active |-> io_oe_n == 5'h1f) else $error("pin pulled while asleep");
   chk_sleep_entry: assert property (@(posedge clk_sys) disable iff (!resetn)
      $rose(sleep_active) |-> !$past(wake_sleep_pin)) else $error("sleep with wake pin high");
   chk_sleep_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
      sleep_active && !wake_sleep_pin && !$past(wake_sleep_pin) && !$past(wake_sleep_pin, 2)
      |=> sleep_active) else $error("left sleep with wake pin low");
   chk_wake_exit: assert property (@(posedge clk_sys) disable iff (!resetn)
      sleep_active && wake_sleep_pin |-> ##[1:4] !sleep_active) else $error("no wake on pin high");
   chk_sleep_ticks: assert property (@(posedge clk_sys) disable iff (!resetn)
      sleep_active |-> !mclk_tick && !logic_tick) else $error("ticks running while asleep");
   // wake restart period: state cleared and master tick still stopped
   sequence s_restart;
      (timer_done == 4'h0 && !mclk_tick) [*3];
   endsequence
   chk_wake_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
      $fell(sleep_active) |-> s_restart) else $error("state kept across wake");
endmodule

bind csio_top csio_properties csio_properties_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .wake_sleep_pin(wake_sleep_pin), .din_pin(din_pin), .io_in(io_in), .io_out(io_out),
   .io_oe_n(io_oe_n), .sleep_active(sleep_active), .mclk_tick(mclk_tick),
   .logic_tick(logic_tick), .timer_done(timer_done));

`default_nettype wire

// File: tb/csio_board.sv
`timescale 1ns/1ps
`default_nettype none

module csio_board
   import csio_pkg::*;
(
   input wire logic [NUM_IO-1:0] io_out, // device drive value
   input wire logic [NUM_IO-1:0] io_oe_n, // device pull enable
   input wire logic [NUM_IO-1:0] board_low, // board pulls pin low
   input wire logic wake_drive, // board wake level
   input wire logic [NUM_DIN-1:0] din_drive, // board input levels
   output logic wake_sleep_pin, // to device
   output logic [NUM_DIN-1:0] din_pin, // to device
   output logic [NUM_IO-1:0] io_in // resolved pin level
);
   // pull-up wire: either side may pull low, never driven high
   assign io_in = ~((~io_oe_n & ~io_out) | board_low);
   // board logic alone raises the pin to wake the device
   assign wake_sleep_pin = wake_drive;
   assign din_pin = din_drive;
endmodule

`default_nettype wire

// File: tb/clock_sleep_and_io_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end

module clock_sleep_and_io_control_bench;
   import csio_pkg::*;
   typedef struct packed {logic [5:0] a; logic [31:0] d; logic [31:0] e;} csio_row_type;
   localparam int unsigned MD = 2, LD = 2, OC = 4;
   logic clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [3:0] avs_byteenable = 4'hf, timer_done;
   logic avs_waitrequest, wake_sleep_pin, sleep_active, mclk_tick, logic_tick;
   logic wake_drive = 1'b1;
   logic [1:0] din_drive = 2'b10, din_pin;
   logic [4:0] board_low = 5'h00, io_in, io_out, io_oe_n;
   int mismatches = 0, check_count = 0, mcnt = 0, lcnt = 0, m0, l0;
   // write rows: address, data written, value read back
   csio_row_type rows [7] = '{'{REG_SIGNATURE, 32'ha5c3_0f96, 32'ha5c3_0f96},
      '{REG_CONFIG, 32'hffff_ff7c, 32'h7c}, '{REG_MACRO, 32'hffff_ffff, 32'h1ff},
      '{REG_PINSEL, 32'hffff_ffff, 32'h7fff}, '{REG_TSTEP0 + 6'h04, 32'hff, 32'h7f},
      '{REG_INPUTS, 32'hffff_ffff, 32'hfe}, '{6'h3c, 32'hffff_ffff, 32'h0}};

   csio_top #(.MDIV(MD), .LDIV(LD), .OSC_CYC(OC)) csio_top_i (.clk_sys(clk_sys),
      .resetn(resetn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .wake_sleep_pin(wake_sleep_pin), .din_pin(din_pin), .io_in(io_in), .io_out(io_out),
      .io_oe_n(io_oe_n), .sleep_active(sleep_active), .mclk_tick(mclk_tick),
      .logic_tick(logic_tick), .timer_done(timer_done));
   csio_board csio_board_i (.io_out(io_out), .io_oe_n(io_oe_n), .board_low(board_low),
      .wake_drive(wake_drive), .din_drive(din_drive), .wake_sleep_pin(wake_sleep_pin),
      .din_pin(din_pin), .io_in(io_in));

   // 200 MHz clock
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   // ticks counted on the falling edge, away from the launch race
   always @(negedge clk_sys) begin
      if (mclk_tick === 1'b1) mcnt++;
      if (logic_tick === 1'b1) lcnt++;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one bus cycle, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 40) begin
         mismatches++;
         $display("ERROR waitrequest expected 0 seen %b", avs_waitrequest);
         conclude();
      end
      @(posedge clk_sys);
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK("readdata", e, rd)
   endtask
   // bounded wait on timer flags (s high) or on the sleep state
   task automatic await(input logic s, input logic [3:0] v);
      int n;
      for (n = 0; n < 300 && (s ? timer_done !== v : sleep_active !== v[0]); n++)
         @(posedge clk_sys);
      if (n >= 300) begin
         mismatches++;
         $display("ERROR wait expected %h seen %h %b", v, timer_done, sleep_active);
         conclude();
      end
   endtask
   task automatic do_reset(input string nm);
      resetn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("waitrequest", 1'b1, avs_waitrequest)
      `CHK("io_oe_n", 5'h1f, io_oe_n)
      `CHK("sleep_active", 1'b0, sleep_active)
      `CHK("timer_done", 4'h0, timer_done)
      @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      rdchk(REG_CONFIG, 32'h7c);
      rdchk(REG_SIGNATURE, SIGNATURE_RST);
      rdchk(REG_MACRO, 32'h100);
      $display("test %s done", nm);
   endtask

   initial begin
      do_reset("power on");
      // masks, read-only and unmapped places
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].e);
      end
      $display("test registers done");
      for (int t = 0; t < 4; t++) bus(1'b1, REG_TSTEP0 + 6'(4 * t), 32'h0);
      bus(1'b1, REG_TCTRL, 32'h1);
      repeat (16) @(posedge clk_sys);
      `CHK("timer_done", 4'h0, timer_done)
      await(1'b1, 4'h1);
      rdchk(REG_TSTAT, 32'h10);
      bus(1'b1, REG_TSTAT, 32'h10);
      `CHK("timer_done", 4'h0, timer_done)
      bus(1'b1, REG_TCTRL, 32'hf);
      await(1'b1, 4'hf);
      $display("test timers done");
      // pins 0 and 1 outputs from macro bits 0 and 1, board pulls pin 3
      bus(1'b1, REG_CONFIG, 32'h70);
      bus(1'b1, REG_PINSEL, 32'h8);
      bus(1'b1, REG_MACRO, 32'h102);
      board_low <= 5'h08;
      repeat (20) @(posedge clk_sys);
      `CHK("io_oe_n", 5'h1e, io_oe_n)
      rdchk(REG_INPUTS, 32'hd2);
      $display("test pins done");
      wake_drive <= 1'b0;
      repeat (20) @(posedge clk_sys);
      `CHK("sleep_active", 1'b0, sleep_active)
      bus(1'b1, REG_CONFIG, 32'h71);
      await(1'b0, 4'h1);
      `CHK("io_oe_n", 5'h1f, io_oe_n)
      // one-cycle wake pulse: restart ends with the pin low, so back to sleep
      wake_drive <= 1'b1;
      @(posedge clk_sys);
      wake_drive <= 1'b0;
      await(1'b0, 4'h0);
      await(1'b0, 4'h1);
      wake_drive <= 1'b1;
      await(1'b0, 4'h0);
      repeat (OC + 6) @(posedge clk_sys);
      `CHK("timer_done", 4'h0, timer_done)
      rdchk(REG_MACRO, 32'h100);
      rdchk(REG_CONFIG, 32'h71);
      $display("test pin sleep done");
      bus(1'b1, REG_CONFIG, 32'h73);
      wake_drive <= 1'b0;
      repeat (20) @(posedge clk_sys);
      `CHK("sleep_active", 1'b0, sleep_active)
      bus(1'b1, REG_MACRO, 32'h0);
      await(1'b0, 4'h1);
      din_drive <= 2'b01;
      repeat (10) @(posedge clk_sys);
      `CHK("sleep_active", 1'b1, sleep_active)
      rdchk(REG_INPUTS, 32'h100);
      wake_drive <= 1'b1;
      await(1'b0, 4'h0);
      repeat (OC + 6) @(posedge clk_sys);
      $display("test request sleep done");
      // a running timer must not advance while ce is low
      bus(1'b1, REG_TCTRL, 32'h1);
      ce <= 1'b0;
      repeat (100) @(posedge clk_sys);
      `CHK("timer_done", 4'h0, timer_done)
      ce <= 1'b1;
      await(1'b1, 4'h1);
      $display("test clock enable done");
      m0 = mcnt;
      l0 = lcnt;
      repeat (400) @(posedge clk_sys);
      `CHK("mclk_tick count", 1'b1, (mcnt - m0) inside {[199:201]})
      `CHK("logic_tick count", 1'b1, (lcnt - l0) inside {[99:101]})
      $display("test tick rates done");
      do_reset("mid run");
      conclude();
   end
endmodule

`default_nettype wire
